// file: core/sic_target.sv
// sensor end: two-wire target with power-up interface selection
// Behaviour
// (R1) strap level caught once after power-up
// (R2) interface type never changes afterwards
// (R3) strap low selects two-wire, else serial
// (R4) target only, single 7-bit bus address
// (R5) controller opens with start condition
// (R6) shift eight bits MSB first after start
// (R7) ack own address with write bit
// (R8) mismatch or read bit: idle, no ack
// (R9) register address byte follows address
// (R10) one to four data bytes, MSB first
// (R11) stop ends transfer, back to idle
// (R12) misplaced start or stop aborts to idle
// (R13) bus address is 0x41
// (R14) write: start, address, register, data, stop
// (R15) read: start, read address, register, data, stop; the target does not ack a read address and returns to idle
// (R16) ignore traffic while measurement-ready high
// (R17) serve nothing before first ready pulse
// (R18) synchronise lines, detect edges from samples
`timescale 1ns/1ps
module sic_target
   import sic_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic         if_sel,
   input  wire logic         meas_ready,
   sic_bus_if.dev            bus,
   output logic              i2c_mode,
   output sic_pkg::sic_byte_t reg_addr,
   output sic_pkg::sic_byte_t wr_data,
   output sic_pkg::sic_idx_t wr_index,
   output logic              wr_valid,
   output logic              xfer_done,
   output sic_pkg::sic_cnt_t xfer_bytes
);

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic        sel_m_ff;
   logic        sel_s_ff;
   logic [1:0]  cap_ff;
   logic        mode_ff;
   logic        rdy_p_ff;
   logic        armed_ff;
   logic [1:0]  bus_m_ff;
   logic [1:0]  bus_s_ff;
   logic [1:0]  bus_p_ff;
   sic_dev_st_t st_ff;
   sic_dev_st_t nxt_st;
   sic_phase_t  ph_ff;
   sic_phase_t  nxt_ph;
   sic_cnt_t    cnt_ff;
   sic_cnt_t    nxt_cnt;
   sic_byte_t   shift_ff;
   sic_byte_t   nxt_shift;
   sic_cnt_t    nb_ff;
   sic_cnt_t    nxt_nb;
   sic_byte_t   reg_ff;
   sic_byte_t   nxt_reg;
   sic_byte_t   wdata_ff;
   sic_byte_t   nxt_wdata;
   sic_idx_t    idx_ff;
   sic_idx_t    nxt_idx;
   logic        wvalid_ff;
   logic        nxt_wvalid;
   logic        done_ff;
   logic        nxt_done;
   logic        sda_oe_n_ff;

   // ---------------------------------------------------------------
   // power-up interface selection
   // ---------------------------------------------------------------
   // the strap is sampled only after the synchroniser has settled, then frozen
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sel_m_ff <= 1'b1;
         sel_s_ff <= 1'b1;
         cap_ff   <= 2'h0;
         mode_ff  <= 1'b0;
      end else begin
         sel_m_ff <= if_sel;
         sel_s_ff <= sel_m_ff;
         if (cap_ff != SIC_Q_LAST) begin
            cap_ff <= cap_ff + 2'h1;
         end
         if (cap_ff == SIC_SEL_SETTLE) begin
            mode_ff <= (sel_s_ff == SIC_SEL_I2C); // R1 R3
         end
      end
   end
   // no other assignment to mode_ff exists besides reset: fixed until the next reset_n assertion (R2)

   // ---------------------------------------------------------------
   // measurement-ready gating
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdy_p_ff <= 1'b0;
         armed_ff <= 1'b0;
      end else begin
         rdy_p_ff <= meas_ready;
         if (meas_ready && !rdy_p_ff) begin
            armed_ff <= 1'b1; // R17
         end
      end
   end

   wire active = mode_ff & armed_ff & ~meas_ready; // R16 R17

   // ---------------------------------------------------------------
   // line synchronisers and condition detection
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bus_m_ff <= 2'h3;
         bus_s_ff <= 2'h3;
         bus_p_ff <= 2'h3;
      end else begin
         bus_m_ff <= {bus.scl, bus.sda}; // R18
         bus_s_ff <= bus_m_ff;
         bus_p_ff <= bus_s_ff;
      end
   end

   wire scl_s     = bus_s_ff[1];
   wire sda_s     = bus_s_ff[0];
   wire scl_p     = bus_p_ff[1];
   wire sda_p     = bus_p_ff[0];
   wire start_det = scl_s & scl_p & sda_p & ~sda_s; // R5 R18
   wire stop_det  = scl_s & scl_p & ~sda_p & sda_s; // R11 R18
   wire scl_rise  = scl_s & ~scl_p;
   wire scl_fall  = ~scl_s & scl_p;
   wire addr_hit  = (shift_ff[7:1] == SIC_DEV_ADDR) && (shift_ff[0] == SIC_RW_WRITE); // R4 R7 R13
   wire data_room = nb_ff < SIC_MAX_BYTES; // R10
   // a stop arrives inside the first bit slot, whose scl rise was already shifted in
   wire end_ok    = (st_ff == DS_RX) && (ph_ff == PH_DATA) && (cnt_ff == 3'h1)
                    && (nb_ff != 3'h0);

   // ---------------------------------------------------------------
   // transfer sequencer
   // ---------------------------------------------------------------
   always_comb begin
      nxt_st     = st_ff;
      nxt_ph     = ph_ff;
      nxt_cnt    = cnt_ff;
      nxt_shift  = shift_ff;
      nxt_nb     = nb_ff;
      nxt_reg    = reg_ff;
      nxt_wdata  = wdata_ff;
      nxt_idx    = idx_ff;
      nxt_wvalid = 1'b0;
      nxt_done   = 1'b0;
      if (!active) begin
         nxt_st = DS_IDLE; // R16
      end else if (start_det) begin
         if (st_ff == DS_IDLE) begin
            nxt_st  = DS_RX; // R6
            nxt_ph  = PH_ADDR;
            nxt_cnt = 3'h0;
            nxt_nb  = 3'h0;
         end else begin
            nxt_st = DS_IDLE; // R12
         end
      end else if (stop_det) begin
         nxt_st   = DS_IDLE; // R11 R12
         nxt_done = end_ok; // R11
      end else begin
         unique case (st_ff)
            DS_IDLE: begin
               nxt_st = DS_IDLE;
            end
            DS_RX: begin
               if (scl_rise) begin
                  nxt_shift = {shift_ff[6:0], sda_s}; // R6 R10
                  nxt_cnt   = cnt_ff + 3'h1;
                  if (cnt_ff == SIC_LAST_BIT) begin
                     nxt_st = DS_WAIT;
                  end
               end
            end
            DS_WAIT: begin
               if (scl_fall) begin
                  unique case (ph_ff)
                     PH_ADDR: begin
                        nxt_st = addr_hit ? DS_ACK : DS_IDLE; // R7 R8
                     end
                     PH_REG: begin
                        nxt_reg = shift_ff; // R9
                        nxt_st  = DS_ACK;
                     end
                     PH_DATA: begin
                        if (data_room) begin
                           nxt_wdata  = shift_ff; // R10
                           nxt_idx    = nb_ff[1:0];
                           nxt_wvalid = 1'b1;
                           nxt_nb     = nb_ff + 3'h1;
                           nxt_st     = DS_ACK;
                        end else begin
                           nxt_st = DS_IDLE; // R10
                        end
                     end
                  endcase
               end
            end
            DS_ACK: begin
               if (scl_fall) begin
                  nxt_st  = DS_RX;
                  nxt_cnt = 3'h0;
                  nxt_ph  = (ph_ff == PH_ADDR) ? PH_REG : PH_DATA; // R9 R14
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff    <= DS_IDLE;
         ph_ff    <= PH_ADDR;
         cnt_ff   <= 3'h0;
         shift_ff <= 8'h00;
         nb_ff    <= 3'h0;
      end else begin
         st_ff    <= nxt_st;
         ph_ff    <= nxt_ph;
         cnt_ff   <= nxt_cnt;
         shift_ff <= nxt_shift;
         nb_ff    <= nxt_nb;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_ff      <= 8'h00;
         wdata_ff    <= 8'h00;
         idx_ff      <= 2'h0;
         wvalid_ff   <= 1'b0;
         done_ff     <= 1'b0;
         sda_oe_n_ff <= 1'b1;
      end else begin
         reg_ff      <= nxt_reg;
         wdata_ff    <= nxt_wdata;
         idx_ff      <= nxt_idx;
         wvalid_ff   <= nxt_wvalid;
         done_ff     <= nxt_done;
         sda_oe_n_ff <= (nxt_st != DS_ACK); // R7
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // the target never drives the clock line and only ever pulls data low
   assign bus.d_sda_o   = 1'b0; // R4
   assign bus.d_sda_oe_n = sda_oe_n_ff;
   assign i2c_mode      = mode_ff;
   assign reg_addr      = reg_ff;
   assign wr_data       = wdata_ff;
   assign wr_index      = idx_ff;
   assign wr_valid      = wvalid_ff;
   assign xfer_done     = done_ff;
   assign xfer_bytes    = nb_ff;

endmodule

// file: core/sic_pkg.sv
// shared constants and types for the sensor two-wire control port
package sic_pkg;

   // ---------------------------------------------------------------
   // bus identity and framing
   // ---------------------------------------------------------------
   localparam logic [6:0] SIC_DEV_ADDR   = 7'h41;
   localparam logic       SIC_RW_WRITE   = 1'b0;
   localparam logic       SIC_RW_READ    = 1'b1;
   localparam logic       SIC_SEL_I2C    = 1'b0;
   localparam logic [2:0] SIC_MAX_BYTES  = 3'h4;
   localparam logic [2:0] SIC_LAST_BIT   = 3'h7;
   localparam logic [3:0] SIC_ACK_BIT    = 4'h8;
   localparam logic [1:0] SIC_SEL_SETTLE = 2'h2;
   localparam logic [1:0] SIC_Q_LAST     = 2'h3;
   localparam logic [2:0] SIC_HDR_BYTES  = 3'h2;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int         SIC_CLK_NS        = 10;
   localparam int         SIC_SCL_PERIOD_NS = 10000;
   localparam int         SIC_QTR_CYC_I     = SIC_SCL_PERIOD_NS / (4 * SIC_CLK_NS);
   localparam logic [8:0] SIC_QTR_LAST      = 9'(SIC_QTR_CYC_I - 1);

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef logic [7:0]  sic_byte_t;
   typedef logic [31:0] sic_word_t;
   typedef logic [2:0]  sic_cnt_t;
   typedef logic [1:0]  sic_idx_t;

   typedef enum logic [1:0] {DS_IDLE, DS_RX, DS_WAIT, DS_ACK} sic_dev_st_t;
   typedef enum logic [1:0] {PH_ADDR, PH_REG, PH_DATA} sic_phase_t;
   typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} sic_host_st_t;

endpackage

// file: core/sic_bus_if.sv
// two-wire bus between controller and target, with open-drain resolution
`timescale 1ns/1ps
interface sic_bus_if;
   logic h_scl_o;
   logic h_scl_oe_n;
   logic h_sda_o;
   logic h_sda_oe_n;
   logic d_sda_o;
   logic d_sda_oe_n;
   logic scl;
   logic sda;

   // pulled high unless an enabled driver pulls low
   assign scl = h_scl_oe_n | h_scl_o;
   assign sda = (h_sda_oe_n | h_sda_o) & (d_sda_oe_n | d_sda_o);

   modport host (output h_scl_o, output h_scl_oe_n, output h_sda_o, output h_sda_oe_n,
                 input scl, input sda);
   modport dev  (output d_sda_o, output d_sda_oe_n, input scl, input sda);
endinterface

// file: core/sic_ctrl.sv
// controller end: two-wire master issuing register writes and reads
`timescale 1ns/1ps
module sic_ctrl
   import sic_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          reset_n,
   input  wire logic          meas_ready,
   input  wire logic          go,
   input  wire logic          rw,
   input  sic_pkg::sic_byte_t reg_addr,
   input  sic_pkg::sic_cnt_t  nbytes,
   input  sic_pkg::sic_word_t wdata,
   sic_bus_if.host            bus,
   output logic               can_start,
   output logic               busy,
   output logic               done,
   output logic               nack,
   output sic_pkg::sic_word_t rdata
);

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic         rdy_m_ff;
   logic         rdy_s_ff;
   logic         rdy_p_ff;
   logic         armed_ff;
   logic         sda_m_ff;
   logic         sda_s_ff;
   sic_host_st_t st_ff;
   logic [8:0]   div_ff;
   logic [1:0]   q_ff;
   logic [3:0]   bit_ff;
   sic_cnt_t     byte_ff;
   sic_cnt_t     n_ff;
   logic         rw_ff;
   sic_byte_t    reg_ff;
   sic_word_t    wd_ff;
   sic_byte_t    tx_ff;
   sic_byte_t    rx_ff;
   logic         ackv_ff;
   logic         scl_ff;
   logic         sda_ff;
   logic         done_ff;
   logic         nack_ff;
   sic_word_t    rdata_ff;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   wire       tick      = (st_ff != HS_IDLE) && (div_ff == SIC_QTR_LAST);
   wire       rd_data   = (rw_ff == SIC_RW_READ) && (byte_ff >= SIC_HDR_BYTES);
   wire       last_byte = (byte_ff == (n_ff + SIC_HDR_BYTES - 3'h1));
   wire       is_ack    = (bit_ff == SIC_ACK_BIT);
   wire       ack_val   = rd_data ? last_byte : 1'b1;
   wire       bit_val   = is_ack ? ack_val : (rd_data | tx_ff[7]);
   wire       accept    = go & can_start;
   wire [5:0] wd_shift  = {SIC_MAX_BYTES - nbytes, 3'h0};
   // data bytes leave from the top of wd_ff, so align the word MSB first
   wire sic_byte_t nxt_tx = (byte_ff == 3'h0) ? reg_ff : wd_ff[31:24];

   assign can_start = (st_ff == HS_IDLE) & armed_ff & ~rdy_s_ff;

   // ---------------------------------------------------------------
   // synchronisers and ready tracking
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdy_m_ff <= 1'b0;
         rdy_s_ff <= 1'b0;
         rdy_p_ff <= 1'b0;
         armed_ff <= 1'b0;
         sda_m_ff <= 1'b1;
         sda_s_ff <= 1'b1;
      end else begin
         rdy_m_ff <= meas_ready;
         rdy_s_ff <= rdy_m_ff;
         rdy_p_ff <= rdy_s_ff;
         sda_m_ff <= bus.sda;
         sda_s_ff <= sda_m_ff;
         if (rdy_s_ff && !rdy_p_ff) begin
            armed_ff <= 1'b1; // R17
         end
      end
   end

   // ---------------------------------------------------------------
   // quarter-bit divider
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_ff <= 9'h000;
      end else if (st_ff == HS_IDLE || tick) begin
         div_ff <= 9'h000;
      end else begin
         div_ff <= div_ff + 9'h001;
      end
   end

   // ---------------------------------------------------------------
   // bus sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff    <= HS_IDLE;
         q_ff     <= 2'h0;
         bit_ff   <= 4'h0;
         byte_ff  <= 3'h0;
         n_ff     <= 3'h1;
         rw_ff    <= SIC_RW_WRITE;
         reg_ff   <= 8'h00;
         wd_ff    <= 32'h0000_0000;
         tx_ff    <= 8'h00;
         rx_ff    <= 8'h00;
         ackv_ff  <= 1'b1;
         scl_ff   <= 1'b1;
         sda_ff   <= 1'b1;
         done_ff  <= 1'b0;
         nack_ff  <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end else begin
         done_ff <= 1'b0;
         if (accept) begin
            st_ff    <= HS_START; // R16
            q_ff     <= 2'h0;
            n_ff     <= nbytes;
            rw_ff    <= rw;
            reg_ff   <= reg_addr;
            wd_ff    <= wdata << wd_shift; // R10
            tx_ff    <= {SIC_DEV_ADDR, rw}; // R13 R14 R15
            byte_ff  <= 3'h0;
            bit_ff   <= 4'h0;
            nack_ff  <= 1'b0;
            rdata_ff <= 32'h0000_0000;
         end else if (tick) begin
            q_ff <= q_ff + 2'h1;
            unique case (st_ff)
               HS_IDLE: begin
                  q_ff <= 2'h0;
               end
               HS_START: begin
                  if (q_ff == 2'h1) begin
                     sda_ff <= 1'b0; // R5
                  end
                  if (q_ff == SIC_Q_LAST) begin
                     scl_ff <= 1'b0;
                     st_ff  <= HS_BIT;
                  end
               end
               HS_BIT: begin
                  unique case (q_ff)
                     2'h0: sda_ff <= bit_val;
                     2'h1: scl_ff <= 1'b1;
                     2'h2: begin
                        if (is_ack) begin
                           ackv_ff <= sda_s_ff;
                        end else begin
                           rx_ff <= {rx_ff[6:0], sda_s_ff};
                        end
                     end
                     2'h3: begin
                        scl_ff <= 1'b0;
                        if (!is_ack) begin
                           bit_ff <= bit_ff + 4'h1;
                           tx_ff  <= {tx_ff[6:0], 1'b0};
                        end else begin
                           bit_ff <= 4'h0;
                           if (rd_data) begin
                              rdata_ff <= {rdata_ff[23:0], rx_ff};
                           end
                           if (!rd_data && ackv_ff) begin
                              nack_ff <= 1'b1;
                              st_ff   <= HS_STOP;
                           end else if (last_byte) begin
                              st_ff <= HS_STOP;
                           end else begin
                              byte_ff <= byte_ff + 3'h1;
                              tx_ff   <= nxt_tx;
                              if (byte_ff >= SIC_HDR_BYTES - 3'h1 && rw_ff == SIC_RW_WRITE) begin
                                 wd_ff <= {wd_ff[23:0], 8'h00};
                              end
                           end
                        end
                     end
                  endcase
               end
               HS_STOP: begin
                  unique case (q_ff)
                     2'h0: sda_ff <= 1'b0;
                     2'h1: scl_ff <= 1'b1;
                     2'h2: sda_ff <= 1'b1;
                     2'h3: begin
                        st_ff   <= HS_IDLE;
                        done_ff <= 1'b1;
                     end
                  endcase
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign bus.h_scl_o    = 1'b0;
   assign bus.h_scl_oe_n = scl_ff;
   assign bus.h_sda_o    = 1'b0;
   assign bus.h_sda_oe_n = sda_ff;
   assign busy           = (st_ff != HS_IDLE);
   assign done           = done_ff;
   assign nack           = nack_ff;
   assign rdata          = rdata_ff;

endmodule

// file: test/sic_bus_assertions.sv
// bus-level checks between the controller and the sensor target
`timescale 1ns/1ps
module sic_bus_assertions
   import sic_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic scl,
   input wire logic sda,
   input wire logic d_sda_oe_n
);
   // ---------------------------------------------------------------
   // frame tracking
   // ---------------------------------------------------------------
   logic       scl_ff;
   logic       sda_ff;
   logic [3:0] bit_ff;
   logic [2:0] byte_ff;
   logic [9:0] hi_ff;
   logic [10:0] low_ff;
   sic_byte_t  sh_ff;
   wire        start_w = scl & scl_ff & sda_ff & ~sda;
   wire        stop_w  = scl & scl_ff & ~sda_ff & sda;
   wire        rise_w  = scl & ~scl_ff;

   // lines idle high, so the samples reset high to avoid a false edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         {scl_ff, sda_ff} <= 2'h3;
         {bit_ff, byte_ff, hi_ff, sh_ff} <= '0;
         low_ff <= 11'h000;
      end else begin
         scl_ff <= scl;
         sda_ff <= sda;
         hi_ff <= scl ? hi_ff + {9'h000, ~&hi_ff} : 10'h000;
         // ack length counted here, since a delay range that long is too costly
         low_ff <= d_sda_oe_n ? 11'h000 : low_ff + {10'h000, ~&low_ff};
         if (start_w) begin
            bit_ff <= 4'h0;
            byte_ff <= 3'h0;
         end else if (rise_w) begin
            bit_ff <= (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
            byte_ff <= byte_ff + {2'h0, bit_ff == 4'h8 && byte_ff != 3'h7};
            sh_ff <= {sh_ff[6:0], sda};
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   property p_start_scl; start_w |-> ##[1:600] !scl; endproperty
   a_start_scl: assert property (p_start_scl)
      else $error("scl held high after start");
   property p_ack_bit; $fell(d_sda_oe_n) |-> bit_ff == 4'h8 && !scl; endproperty
   a_ack_bit: assert property (p_ack_bit)
      else $error("ack not after eighth bit");
   property p_ack_rel; $rose(d_sda_oe_n) |-> bit_ff == 4'h0 && !scl; endproperty
   a_ack_rel: assert property (p_ack_rel)
      else $error("ack not released after ninth clock");
   property p_ack_len; $rose(d_sda_oe_n) |-> low_ff >= 11'h008; endproperty
   a_ack_len: assert property (p_ack_len)
      else $error("ack length wrong");
   property p_ack_hold; !d_sda_oe_n |-> low_ff < 11'h44c; endproperty
   a_ack_hold: assert property (p_ack_hold)
      else $error("ack held too long");
   property p_ack_addr;
      $fell(d_sda_oe_n) && byte_ff == 3'h0 |-> sh_ff == {SIC_DEV_ADDR, SIC_RW_WRITE};
   endproperty
   a_ack_addr: assert property (p_ack_addr)
      else $error("ack on foreign address or read bit");
   property p_ack_max; $fell(d_sda_oe_n) |-> byte_ff <= 3'h5; endproperty
   a_ack_max: assert property (p_ack_max)
      else $error("ack beyond four data bytes");
   property p_stop_idle; stop_w |-> d_sda_oe_n [*8]; endproperty
   a_stop_idle: assert property (p_stop_idle)
      else $error("target drives after stop");
   property p_sync; $fell(d_sda_oe_n) |-> !$past(scl) && !$past(scl, 2); endproperty
   a_sync: assert property (p_sync)
      else $error("ack driven before scl fall was synchronised");
   property p_scl_high; $fell(scl) |-> hi_ff >= 10'h1ea; endproperty
   a_scl_high: assert property (p_scl_high)
      else $error("scl high phase too short");
endmodule

// file: test/sensor_i2c_control_port_bench.sv
// testbench: controller and target back to back, plus a bench-driven bus
`timescale 1ns/1ps
module sensor_i2c_control_port_bench;
   import sic_pkg::*;
   localparam int Q = 8;
   logic       clk = 1'b0;
   logic       reset_n = 1'b0;
   logic       rst2_n = 1'b0;
   logic       sel1 = 1'b0;
   logic       sel2 = 1'b0;
   logic       meas = 1'b0;
   logic       go = 1'b0;
   logic       rw = 1'b0;
   sic_byte_t  ra = 8'h00;
   sic_cnt_t   nb = 3'h1;
   sic_word_t  wd = 32'h0;
   logic       mode1, mode2, wv1, wv2, xd1, xd2, can_start, busy, done, nack;
   sic_byte_t  rga1, rga2, wdt1, wdt2;
   sic_idx_t   wix1, wix2;
   sic_cnt_t   xb1, xb2;
   sic_word_t  rdata;
   sic_byte_t  cap1 [4];
   sic_byte_t  cap2 [4];
   logic [7:0] ackv;
   int         nd1 = 0, nd2 = 0, error_cnt = 0, n_tests = 0, cyc = 0;

   sic_bus_if i_bus ();
   sic_bus_if i_bus2 ();
   sic_target i_sic_target (.clk, .reset_n, .if_sel(sel1), .meas_ready(meas), .bus(i_bus),
      .i2c_mode(mode1), .reg_addr(rga1), .wr_data(wdt1), .wr_index(wix1), .wr_valid(wv1),
      .xfer_done(xd1), .xfer_bytes(xb1));
   // second target faces the bench directly, so faulty frames can be sent
   sic_target i_sic_target_2 (.clk, .reset_n(rst2_n), .if_sel(sel2), .meas_ready(meas),
      .bus(i_bus2), .i2c_mode(mode2), .reg_addr(rga2), .wr_data(wdt2), .wr_index(wix2),
      .wr_valid(wv2), .xfer_done(xd2), .xfer_bytes(xb2));
   sic_ctrl i_sic_ctrl (.clk, .reset_n, .meas_ready(meas), .go, .rw, .reg_addr(ra),
      .nbytes(nb), .wdata(wd), .bus(i_bus), .can_start, .busy, .done, .nack, .rdata);
   sic_bus_assertions u_chk (.clk, .reset_n, .scl(i_bus.scl), .sda(i_bus.sda),
      .d_sda_oe_n(i_bus.d_sda_oe_n));

   always #5 clk = ~clk;

   always @(posedge clk) begin
      cyc++;
      if (wv1 === 1'b1) cap1[wix1] = wdt1;
      if (wv2 === 1'b1) cap2[wix2] = wdt2;
      if (xd1 === 1'b1) nd1++;
      if (xd2 === 1'b1) nd2++;
      if (cyc == 90000) begin
         error_cnt++;
         wrap_up();
      end
   end

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task chk(input sic_word_t seen, input sic_word_t exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task wrap_up();
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // one quarter bit on the bench bus; a released line reads high
   task line2(input logic c, input logic d);
      i_bus2.h_scl_oe_n = c;
      i_bus2.h_sda_oe_n = d;
      tick(Q);
   endtask

   task bb_bit(input logic b);
      line2(1'b0, b);
      line2(1'b1, b);
      line2(1'b1, b);
      line2(1'b0, b);
   endtask

   // start, n bytes from the top of f, extra stray bits, stop
   task bb_frame(input logic [63:0] f, input int n, input int extra);
      int i, j;
      ackv = 8'h00;
      line2(1'b1, 1'b1);
      line2(1'b1, 1'b0);
      line2(1'b0, 1'b0);
      for (i = 0; i < n; i++) begin
         for (j = 0; j < 8; j++) bb_bit(f[63 - 8 * i - j]);
         line2(1'b0, 1'b1);
         line2(1'b1, 1'b1);
         ackv[i] = ~i_bus2.sda;
         line2(1'b1, 1'b1);
         line2(1'b0, 1'b1);
      end
      for (j = 0; j < extra; j++) bb_bit(1'b0);
      line2(1'b0, 1'b0);
      line2(1'b1, 1'b0);
      line2(1'b1, 1'b1);
   endtask

   task arm();
      meas = 1'b1;
      tick(20);
      meas = 1'b0;
      tick(20);
   endtask

   task ctrl_xfer(input logic r, input sic_byte_t a, input sic_cnt_t n, input sic_word_t w);
      while (can_start !== 1'b1) tick(1);
      rw = r;
      ra = a;
      nb = n;
      wd = w;
      go = 1'b1;
      tick(1);
      go = 1'b0;
      while (done !== 1'b1) tick(1);
      tick(5);
   endtask

   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      {i_bus2.h_scl_o, i_bus2.h_sda_o} = 2'h0;
      {i_bus2.h_scl_oe_n, i_bus2.h_sda_oe_n} = 2'h3;
      tick(16);
      reset_n = 1'b1;
      rst2_n = 1'b1;
      tick(6);
      chk(mode1, 1'b1);
      chk(mode2, 1'b1);
      sel1 = 1'b1;
      go = 1'b1;
      tick(1);
      go = 1'b0;
      tick(3);
      chk(busy, 1'b0);
      chk(can_start, 1'b0);
      chk(mode1, 1'b1);
      bb_frame(64'h8200000000000000, 1, 0);
      chk(ackv, 8'h00);
      arm();
      ctrl_xfer(SIC_RW_WRITE, 8'h1e, 3'h2, 32'h0000a5c3);
      chk(nack, 1'b0);
      chk(rga1, 8'h1e);
      chk({cap1[0], cap1[1]}, 32'h0000a5c3);
      chk(xb1, 3'h2);
      chk(nd1, 32'h1);
      ctrl_xfer(SIC_RW_READ, 8'h02, 3'h1, 32'h0);
      chk(nack, 1'b1);
      chk(rdata, 32'h0);
      chk(nd1, 32'h1);
      bb_frame(64'h8400000000000000, 1, 0);
      chk(ackv, 8'h00);
      bb_frame(64'h8226112233445500, 7, 0);
      chk(ackv, 8'h3f);
      chk({cap2[0], cap2[1], cap2[2], cap2[3]}, 32'h11223344);
      chk(rga2, 8'h26);
      chk(nd2, 32'h0);
      bb_frame(64'h8205776600000000, 4, 3);
      chk(ackv, 8'h0f);
      chk(nd2, 32'h0);
      bb_frame(64'h8204100000000000, 3, 0);
      chk(ackv, 8'h07);
      chk(nd2, 32'h1);
      chk(xb2, 3'h1);
      chk(cap2[0], 8'h10);
      meas = 1'b1;
      tick(4);
      bb_frame(64'h8204100000000000, 3, 0);
      meas = 1'b0;
      chk(ackv, 8'h00);
      chk(nd2, 32'h1);
      sel2 = 1'b1;
      rst2_n = 1'b0;
      tick(3);
      rst2_n = 1'b1;
      tick(6);
      chk(mode2, 1'b0);
      arm();
      bb_frame(64'h8204100000000000, 3, 0);
      chk(ackv, 8'h00);
      wrap_up();
   end
endmodule
